// [hw/pcihk_regs.sv]
module pcihk_regs
  import pcihk_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pci side
  input wire logic pci_reset_n,
  input wire logic auto_init_en,
  input wire logic pci_access_req,
  output logic pci_retry,
  output logic pci_access_allow,
  // mirror defaults
  output logic [31:0] identity_mirror,
  output logic [31:0] class_mirror,
  output logic [31:0] subsystem_mirror,
  output logic [15:0] latency_interrupt_mirror
);

  pcihk_state_t st_reg;
  pcihk_state_t st_next;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic sel_identity;
  logic sel_class;
  logic sel_subsys;
  logic sel_latency;
  logic sel_cfgdone;
  logic auto_init_sync;
  logic access_req_sync;
  logic pci_reset_sync_n;
  logic allow;
  logic [31:0] rd_word;

  // any of the five mapped hook offsets
  function automatic logic hit(input logic [11:0] a);
    hit = (a == PCIHK_ADDR_IDENTITY) || (a == PCIHK_ADDR_CLASS) ||
          (a == PCIHK_ADDR_SUBSYS) || (a == PCIHK_ADDR_LATENCY) ||
          (a == PCIHK_ADDR_CFGDONE);
  endfunction

  // software view of one hook register, reserved bits forced to zero
  function automatic logic [31:0] read_view(
    input logic [11:0] a,
    input pcihk_state_t s
  );
    if (a == PCIHK_ADDR_IDENTITY)
    begin
      read_view = s.identity_reg;
    end
    else if (a == PCIHK_ADDR_CLASS)
    begin
      read_view = s.class_reg;
    end
    else if (a == PCIHK_ADDR_SUBSYS)
    begin
      read_view = s.subsys_reg;
    end
    else if (a == PCIHK_ADDR_LATENCY)
    begin
      read_view = {16'h0000, s.latency_reg};
    end
    else if (a == PCIHK_ADDR_CFGDONE)
    begin
      read_view = {31'h0000_0000, s.cfgdone_reg};
    end
    else
    begin
      // unmapped offsets read as zero; pslverr flags them
      read_view = 32'h0000_0000;
    end
  endfunction

  // apb decode: writes land in the access phase, reads sample in setup
  assign addr_hit = hit(paddr);
  assign wr_en = psel && penable && pwrite && addr_hit;
  assign rd_en = psel && !penable && !pwrite;
  assign rd_word = read_view(paddr, st_reg);

  assign sel_identity = (paddr == PCIHK_ADDR_IDENTITY);
  assign sel_class = (paddr == PCIHK_ADDR_CLASS);
  assign sel_subsys = (paddr == PCIHK_ADDR_SUBSYS);
  assign sel_latency = (paddr == PCIHK_ADDR_LATENCY);
  assign sel_cfgdone = (paddr == PCIHK_ADDR_CFGDONE);

  // pins only reach logic through the second synchroniser stage
  assign auto_init_sync = st_reg.done_s2_reg;
  assign access_req_sync = st_reg.req_s2_reg;
  assign pci_reset_sync_n = st_reg.pci_rst_s2_reg;

  // without auto-init the host is never held off, whatever the flag says
  assign allow = !auto_init_sync || st_reg.cfgdone_reg;

  always_comb
  begin
    st_next = st_reg;

    st_next.pci_rst_s1_reg = pci_reset_n;
    st_next.pci_rst_s2_reg = st_reg.pci_rst_s1_reg;
    st_next.done_s1_reg = auto_init_en;
    st_next.done_s2_reg = st_reg.done_s1_reg;
    st_next.req_s1_reg = pci_access_req;
    st_next.req_s2_reg = st_reg.req_s1_reg;

    // a write and a read never share a cycle on apb, so the decodes cannot race
    if (wr_en)
    begin
      if (sel_identity)
      begin
        st_next.identity_reg = pwdata;
      end
      else if (sel_class)
      begin
        st_next.class_reg = pwdata;
      end
      else if (sel_subsys)
      begin
        st_next.subsys_reg = pwdata;
      end
      else if (sel_latency)
      begin
        st_next.latency_reg = pwdata[PCIHK_LATENCY_W-1:0];
      end
      else if (sel_cfgdone)
      begin
        st_next.cfgdone_reg = pwdata[PCIHK_CFGDONE_BIT];
      end
    end

    // read data captured in setup so the access phase returns it with no wait
    if (rd_en)
    begin
      st_next.prdata_reg = rd_word;
    end

    // mirrors track the hooks while pci reset is held; the value at release sticks
    if (!pci_reset_sync_n)
    begin
      st_next.identity_mirror_reg = st_reg.identity_reg;
      st_next.class_mirror_reg = st_reg.class_reg;
      st_next.subsys_mirror_reg = st_reg.subsys_reg;
      st_next.latency_mirror_reg = st_reg.latency_reg;
    end
  end

  // identity and class hooks reset to neutral values; boot code loads real codes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '{
        identity_reg: PCIHK_IDENTITY_RESET,
        class_reg: PCIHK_CLASS_RESET,
        subsys_reg: PCIHK_SUBSYS_RESET,
        latency_reg: PCIHK_LATENCY_RESET,
        cfgdone_reg: PCIHK_CFGDONE_RESET,
        prdata_reg: 32'h0000_0000,
        identity_mirror_reg: PCIHK_IDENTITY_RESET,
        class_mirror_reg: PCIHK_CLASS_RESET,
        subsys_mirror_reg: PCIHK_SUBSYS_RESET,
        latency_mirror_reg: PCIHK_LATENCY_RESET,
        pci_rst_s1_reg: 1'b0,
        pci_rst_s2_reg: 1'b0,
        done_s1_reg: 1'b0,
        done_s2_reg: 1'b0,
        req_s1_reg: 1'b0,
        req_s2_reg: 1'b0
      };
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign prdata = st_reg.prdata_reg;
  assign pready = 1'b1;

  // unmapped addresses are flagged rather than silently absorbed
  assign pslverr = psel && penable && !addr_hit;

  assign pci_access_allow = allow;

  // retry follows the synchronised request, two clocks behind the pin
  assign pci_retry = access_req_sync && !allow;

  // limitation: the mirrors are outputs only, software cannot read them here
  assign identity_mirror = st_reg.identity_mirror_reg;
  assign class_mirror = st_reg.class_mirror_reg;
  assign subsystem_mirror = st_reg.subsys_mirror_reg;
  assign latency_interrupt_mirror = st_reg.latency_mirror_reg;

endmodule

// [pkg/pcihk_pkg.sv]
package pcihk_pkg;

  // register byte addresses on the apb bus
  localparam logic [11:0] PCIHK_ADDR_IDENTITY = 12'h394;
  localparam logic [11:0] PCIHK_ADDR_CLASS = 12'h39c;
  localparam logic [11:0] PCIHK_ADDR_SUBSYS = 12'h3a0;
  localparam logic [11:0] PCIHK_ADDR_LATENCY = 12'h3a4;
  localparam logic [11:0] PCIHK_ADDR_CFGDONE = 12'h3ac;

  // arbitrary neutral defaults for the identity hooks
  localparam logic [31:0] PCIHK_IDENTITY_RESET = 32'h0000_0000;
  localparam logic [31:0] PCIHK_CLASS_RESET = 32'h0000_0000;
  localparam logic [31:0] PCIHK_SUBSYS_RESET = 32'h0000_0000;
  localparam logic [15:0] PCIHK_LATENCY_RESET = 16'h0000;
  localparam logic PCIHK_CFGDONE_RESET = 1'b0;

  localparam int PCIHK_LATENCY_W = 16;
  localparam int PCIHK_CFGDONE_BIT = 0;

  typedef struct packed {
    logic [31:0] identity_reg;
    logic [31:0] class_reg;
    logic [31:0] subsys_reg;
    logic [15:0] latency_reg;
    logic cfgdone_reg;
    logic [31:0] prdata_reg;
    logic [31:0] identity_mirror_reg;
    logic [31:0] class_mirror_reg;
    logic [31:0] subsys_mirror_reg;
    logic [15:0] latency_mirror_reg;
    logic pci_rst_s1_reg;
    logic pci_rst_s2_reg;
    logic done_s1_reg;
    logic done_s2_reg;
    logic req_s1_reg;
    logic req_s2_reg;
  } pcihk_state_t;

endpackage

// [verification/pcihk_host.sv]
module pcihk_host
(
  // pci host pins
  output logic pci_reset_n = 1'b0,
  output logic auto_init_en = 1'b1,
  // a refused host retries at once, so its request never drops
  output logic pci_access_req = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
endmodule

// [verification/pcihk_regs_properties.sv]
module pcihk_regs_properties
  import pcihk_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // pci
  input wire logic pci_reset_n,
  input wire logic auto_init_en,
  input wire logic pci_access_req,
  input wire logic pci_retry,
  input wire logic pci_access_allow,
  input wire logic [15:0] latency_interrupt_mirror
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic rd = psel && penable && !pwrite;
  wire logic wr = psel && penable && pwrite;
  AST_HOLD: assert property ($past(pci_access_req, 2) && !pci_access_allow |-> pci_retry)
    else $error("no retry");
  AST_PASS: assert property (pci_access_allow |-> !pci_retry)
    else $error("bad retry");
  AST_LAT: assert property (rd && paddr == PCIHK_ADDR_LATENCY |-> !prdata[31:16])
    else $error("latency upper half");
  AST_DONE: assert property (rd && paddr == PCIHK_ADDR_CFGDONE |-> !prdata[31:1])
    else $error("done upper bits");
  AST_SET: assert property (wr && paddr == PCIHK_ADDR_CFGDONE && pwdata[0] |=> pci_access_allow)
    else $error("not allowed");
  // two sync stages settle before the mirror has to freeze
  AST_FRZ: assert property (pci_reset_n [*4] |-> $stable(latency_interrupt_mirror))
    else $error("mirror moved");
  AST_AUTO: assert property (!auto_init_en [*3] |-> pci_access_allow)
    else $error("held without auto");
  AST_RD: assert property (rd |=> $stable(prdata))
    else $error("read data moved");
endmodule
bind pcihk_regs pcihk_regs_properties props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pci_reset_n, .auto_init_en, .pci_access_req, .pci_retry, .pci_access_allow,
  .latency_interrupt_mirror);

// [verification/testbench.sv]
module testbench import pcihk_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, pci_reset_n, auto_init_en, pci_access_req, pci_retry, pci_access_allow;
  logic [11:0] paddr = 12'h0;
  logic [11:0] adr [5] = '{PCIHK_ADDR_IDENTITY, PCIHK_ADDR_CLASS, PCIHK_ADDR_SUBSYS,
    PCIHK_ADDR_LATENCY, PCIHK_ADDR_CFGDONE};
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [31:0] msk [5] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffff, 32'h1};
  logic [31:0] pat [3] = '{32'h0, 32'hffffffff, 32'ha5a55a5a};
  logic [15:0] latency_interrupt_mirror;
  logic [31:0] im, cm, sm;
  logic ev;
  int n_mismatch = 0, tests_run = 0;
  always #25 pclk = ~pclk;
  pcihk_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pci_reset_n, .auto_init_en, .pci_access_req, .pci_retry, .pci_access_allow,
    .identity_mirror(im), .class_mirror(cm), .subsystem_mirror(sm), .latency_interrupt_mirror);
  pcihk_host host (.pci_reset_n, .auto_init_en, .pci_access_req);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // pass 0 reads reset values, later passes write then read back
    foreach (pat[p])
    begin
      if (p > 0)
        foreach (adr[k])
          xfer(adr[k], 1'b1, pat[p]);
      foreach (adr[k])
      begin
        xfer(adr[k], 1'b0, 32'h0);
        chk("reg", q, pat[p] & msk[k]);
        chk("slverr", ev, 1'b0);
      end
      chk("id mirror", im, pat[p > 0]);
      chk("class mirror", cm, pat[p > 0]);
      chk("subsys mirror", sm, pat[p > 0]);
      chk("pci", {pci_retry, pci_access_allow}, {!pat[p][0], pat[p][0]});
      chk("mirror", latency_interrupt_mirror, pat[p > 0] & 32'hffff);
      host.pci_reset_n <= p > 0;
      repeat (4) @(posedge pclk);
    end
    host.pci_reset_n <= 1'b0;
    host.auto_init_en <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("relatch", latency_interrupt_mirror, 32'h5a5a);
    chk("relatch id", im, 32'ha5a55a5a);
    chk("relatch class", cm, 32'ha5a55a5a);
    chk("relatch subsys", sm, 32'ha5a55a5a);
    xfer(12'h398, 1'b1, 32'hffffffff);
    chk("unmapped wr err", ev, 1'b1);
    xfer(12'h398, 1'b0, 32'h0);
    chk("unmapped rd err", ev, 1'b1);
    chk("unmapped rd", q, 32'h0);
    xfer(PCIHK_ADDR_IDENTITY, 1'b0, 32'h0);
    chk("id kept", q, 32'ha5a55a5a);
    chk("no auto", {pci_retry, pci_access_allow}, 32'h1);
    summarize();
  end
endmodule
